/* File: fsc_em_facility.sv */
// far-end facility model: drives the E lead, times outgoing M-lead breaks
// assumes bench commands change at the falling clock edge
`timescale 1ns/1ps
module fsc_em_facility
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic seizeReq,
	input wire logic mLeadBattery,
	output logic eLeadGnd,
	output int unsigned lastBreak
);
	int unsigned run;

	assign eLeadGnd = seizeReq;

	// length in cycles of the last ground interval on M
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			run <= 0;
			lastBreak <= 0;
		end
		else if (!mLeadBattery)
			run <= run + 1;
		else if (run != 0)
		begin
			lastBreak <= run;
			run <= 0;
		end
	end
endmodule

/* File: fsc_loop_filter.sv */
// loop-current filter: glitch rejection, minimum-break correction, dial detection
// assumes loopClosed already synchronised and msTick one cycle per ms
`timescale 1ns/1ps
module fsc_loop_filter
	import fsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic msTick,
	input wire logic loopClosed,
	output logic offHook,
	output logic dialing
);
	logic accepted;
	logic [3:0] glitchCnt;
	logic [6:0] brkMs;
	logic [8:0] makeMs;

	// ************************************************************
	// decode
	// ************************************************************
	wire differ = loopClosed != accepted;
	wire settle = differ && msTick && (glitchCnt == T_GLITCH_MS - 4'h1);
	wire brkOk = (brkMs < T_BRK_LO_MS) || (brkMs >= T_BRK_MIN_MS);
	wire next_offHook = accepted && brkOk;
	wire makeEdge = next_offHook && !offHook;
	wire [3:0] next_glitchCnt = (!differ || settle) ? 4'h0 :
		(msTick ? glitchCnt + 4'h1 : glitchCnt);
	wire [6:0] next_brkMs = offHook ? 7'h00 :
		((msTick && brkMs != T_HANGUP_MS) ? brkMs + 7'h01 : brkMs);
	wire [8:0] next_makeMs = !offHook ? 9'h000 :
		((msTick && makeMs != T_INTERDIGIT_MS) ? makeMs + 9'h001 : makeMs);
	wire dialSet = makeEdge && brkMs != T_HANGUP_MS;
	wire dialClr = makeMs == T_INTERDIGIT_MS || brkMs == T_HANGUP_MS;

	// ************************************************************
	// state
	// ************************************************************
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			accepted <= 1'b0;
			glitchCnt <= 4'h0;
			brkMs <= BRK_RESET;
			makeMs <= 9'h000;
			offHook <= 1'b0;
			dialing <= 1'b0;
		end
		else
		begin
			if (settle)
				accepted <= loopClosed; // RL12
			glitchCnt <= next_glitchCnt;
			brkMs <= next_brkMs;
			makeMs <= next_makeMs;
			offHook <= next_offHook; // RL13
			dialing <= dialSet || (dialing && !dialClr);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	property p_glitch_reject;
		$changed(accepted) |-> $past(glitchCnt) == T_GLITCH_MS - 4'h1 && $past(msTick);
	endproperty
	a_glitch_reject: assert property (p_glitch_reject) // RL12
		else $error("loop state accepted before glitch time");

	property p_min_break;
		$rose(offHook) |-> $past(brkMs) < T_BRK_LO_MS || $past(brkMs) >= T_BRK_MIN_MS;
	endproperty
	a_min_break: assert property (p_min_break) // RL13
		else $error("break of 30 to 50 ms not stretched");

	property p_break_follows;
		$fell(accepted) |=> !offHook;
	endproperty
	a_break_follows: assert property (p_break_follows) // RL13
		else $error("accepted break not passed out");

	c_stretch: cover property ($rose(offHook) && $past(brkMs) == T_BRK_MIN_MS);
endmodule

/* File: fsc_pkg.sv */
// constants and types shared by the signaling converter
// assumes a single 50 MHz system clock domain
package fsc_pkg;
	// ************************************************************
	// clock and time base
	// ************************************************************
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned MS_PER_SEC = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_SEC;

	// ************************************************************
	// timing in milliseconds
	// ************************************************************
	localparam logic [3:0] T_GLITCH_MS = 4'hF;
	localparam logic [6:0] T_BRK_LO_MS = 7'h1E;
	localparam logic [6:0] T_BRK_MIN_MS = 7'h32;
	localparam logic [6:0] T_HANGUP_MS = 7'h7F;
	localparam logic [8:0] T_INTERDIGIT_MS = 9'h12C;
	localparam logic [12:0] T_RING_HOLD_MS = 13'h1770;
	localparam int T_MDELAY_MS = 16;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [6:0] BRK_RESET = 7'h7F;
	localparam logic [12:0] RING_MS_RESET = 13'h1770;
	// pins start at idle: E lead grounded, loop open, straps clear
	localparam logic [6:0] PIN_SYNC_RESET = 7'h40;

	// ************************************************************
	// application types
	// ************************************************************
	typedef enum logic [1:0] {APP_SF, APP_DX, APP_EM} fsc_app_t;

	function automatic logic is_dc(input fsc_app_t app);
		return app != APP_SF;
	endfunction
endpackage

/* File: fsc_signaling_converter.sv */
// E&M lead to station loop signaling converter, station end
// assumes pins asynchronous to clk_sys; straps static during operation
// Notes on behaviour
// [RL1] normal sense: ring-up drive on while E lead open
// [RL2] inverted sense: ring-up drive on while E lead grounded, any application except ground start with tone companion
// [RL3] ground-start with tone companion: sense selection has no effect
// [RL4] loop start: ring on open E; M ground idle, battery off-hook, pulses
// [RL5] ground start: idle open/ground, ring-ground gives battery, E ground tip-grounds
// [RL6] ringing only from E lead; M lead from station hook state, and in ground start also from the ring-ground request
// [RL7] dc applications: each M-lead change delayed about 16 ms
// [RL8] dc applications: suppression and idle termination switched in automatically
// [RL9] dc applications: repeater disable during idle and dialing, released otherwise
// [RL10] dc: loop start follows cadence, ground start rings continuously
// [RL11] stand-alone E&M behaves as dc application
// [RL12] loop makes or breaks under 15 ms ignored
// [RL13] breaks 30 to 50 ms stretched to 50 ms, longer passed
// [RL14] E lead and loop sense synchronised before use
`timescale 1ns/1ps
module fsc_signaling_converter
	import fsc_pkg::*;
#(
	parameter int unsigned MS_CYCLES_P = MS_CYCLES
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic eLeadGnd,
	input wire logic loopClosed,
	input wire logic invertSense,
	input wire logic groundStart,
	input wire logic ringGndReq,
	input wire logic [1:0] appSel,
	output logic ringUpRelayDrive,
	output logic mLeadBattery,
	output logic tipGround,
	output logic suppressOn,
	output logic idleTermOn,
	output logic repeaterDisable
);
	logic [6:0] pinMeta;
	logic [6:0] pinSync;
	logic [15:0] tickCnt;
	logic msTick;
	logic eRingPhaseD;
	logic ringActive;
	logic [12:0] ringMs;
	logic [T_MDELAY_MS-1:0] mDelay;
	logic offHook;
	logic dialing;

	// ************************************************************
	// synchronised pins
	// ************************************************************
	wire eGndS = pinSync[6];
	wire loopS = pinSync[5];
	wire invS = pinSync[4];
	wire gsS = pinSync[3];
	wire ringGndReqS = pinSync[2];
	wire fsc_app_t app = fsc_app_t'(pinSync[1:0]);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pinMeta <= PIN_SYNC_RESET;
			pinSync <= PIN_SYNC_RESET;
		end
		else
		begin
			pinMeta <= {eLeadGnd, loopClosed, invertSense, groundStart, ringGndReq, appSel};
			pinSync <= pinMeta; // RL14
		end
	end

	// ************************************************************
	// millisecond tick
	// ************************************************************
	wire tickWrap = tickCnt == 16'(MS_CYCLES_P - 1);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tickCnt <= 16'h0000;
			msTick <= 1'b0;
		end
		else
		begin
			tickCnt <= tickWrap ? 16'h0000 : tickCnt + 16'h0001;
			msTick <= tickWrap;
		end
	end

	// ************************************************************
	// station loop
	// ************************************************************
	fsc_loop_filter u_filter (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.msTick(msTick),
		.loopClosed(loopS),
		.offHook(offHook),
		.dialing(dialing)
	);

	// ************************************************************
	// E lead to ringing and tip ground
	// ************************************************************
	wire dc = is_dc(app); // RL11
	wire invEff = invS && !(gsS && app == APP_SF); // RL3
	wire eRingPhase = invEff ? eGndS : !eGndS; // RL1 RL2
	wire eAlt = eRingPhase && !eRingPhaseD;
	wire ringStart = gsS && eAlt && ringMs < T_RING_HOLD_MS && !offHook;
	wire ringStop = offHook || ringMs == T_RING_HOLD_MS;
	wire [12:0] next_ringMs = (eRingPhase != eRingPhaseD) ? 13'h0000 :
		((msTick && ringMs != T_RING_HOLD_MS) ? ringMs + 13'h0001 : ringMs);
	wire lsRing = eRingPhase && !offHook; // RL4
	wire gsRing = ringActive && !offHook && (dc || eRingPhase); // RL5 RL10
	wire next_ringUp = gsS ? gsRing : lsRing; // RL6
	wire next_tipGround = gsS && !eRingPhase && !ringActive; // RL5

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			eRingPhaseD <= 1'b0;
			ringMs <= RING_MS_RESET;
			ringActive <= 1'b0;
		end
		else
		begin
			eRingPhaseD <= eRingPhase;
			ringMs <= next_ringMs;
			ringActive <= ringStart || (ringActive && !ringStop); // RL10
		end
	end

	// ************************************************************
	// station state to M lead and dc helpers
	// ************************************************************
	wire mRaw = offHook || (gsS && ringGndReqS); // RL4 RL5 RL6
	wire next_mLead = dc ? mDelay[T_MDELAY_MS-1] : mRaw; // RL7
	wire idle = !offHook && !next_ringUp;
	wire next_suppress = dc && (!offHook || dialing); // RL8
	wire next_idleTerm = dc && idle; // RL8
	wire next_rptDis = dc && (idle || dialing); // RL9

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			mDelay <= '0;
		else if (msTick)
			mDelay <= {mDelay[T_MDELAY_MS-2:0], mRaw}; // RL7
	end

	// ************************************************************
	// registered outputs
	// ************************************************************
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ringUpRelayDrive <= 1'b0;
			mLeadBattery <= 1'b0;
			tipGround <= 1'b0;
			suppressOn <= 1'b0;
			idleTermOn <= 1'b0;
			repeaterDisable <= 1'b0;
		end
		else
		begin
			ringUpRelayDrive <= next_ringUp;
			mLeadBattery <= next_mLead;
			tipGround <= next_tipGround;
			suppressOn <= next_suppress;
			idleTermOn <= next_idleTerm;
			repeaterDisable <= next_rptDis;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	property p_ring_normal;
		!gsS && !invS && !eGndS && !offHook |=> ringUpRelayDrive;
	endproperty
	a_ring_normal: assert property (p_ring_normal) // RL1
		else $error("no ring-up with open E lead, normal sense");

	property p_ring_invert;
		!gsS && invS && eGndS && !offHook |=> ringUpRelayDrive;
	endproperty
	a_ring_invert: assert property (p_ring_invert) // RL2
		else $error("no ring-up with grounded E lead, inverted sense");

	property p_sense_ignored;
		gsS && app == APP_SF |-> eRingPhase == !eGndS;
	endproperty
	a_sense_ignored: assert property (p_sense_ignored) // RL3
		else $error("sense option acted in ground-start tone use");

	property p_m_ground_idle;
		app == APP_SF && !offHook && !(gsS && ringGndReqS) |=> !mLeadBattery;
	endproperty
	a_m_ground_idle: assert property (p_m_ground_idle) // RL4
		else $error("M lead not grounded on-hook");

	property p_tip_ground;
		gsS && !eRingPhase && !ringActive |=> tipGround;
	endproperty
	a_tip_ground: assert property (p_tip_ground) // RL5
		else $error("no tip ground with E grounded");

	property p_m_delay;
		dc && $rose(mRaw) && mDelay == '0 |=> !mLeadBattery [*8];
	endproperty
	a_m_delay: assert property (p_m_delay) // RL7
		else $error("M lead change not delayed");

	property p_suppress;
		dc && !offHook |=> suppressOn && idleTermOn == !ringUpRelayDrive;
	endproperty
	a_suppress: assert property (p_suppress) // RL8
		else $error("suppression or termination missing while idle");

	property p_rpt_disable;
		!dc |=> !repeaterDisable && !suppressOn && !idleTermOn;
	endproperty
	a_rpt_disable: assert property (p_rpt_disable) // RL9
		else $error("dc helpers active in tone application");

	property p_gs_continuous;
		gsS && dc && ringActive && !offHook |=> ringUpRelayDrive;
	endproperty
	a_gs_continuous: assert property (p_gs_continuous) // RL10
		else $error("ground-start dc ringing interrupted");

	c_ls_ring: cover property (!gsS && $rose(ringUpRelayDrive));
	c_gs_ring: cover property (gsS && $rose(ringActive));
	c_dialing: cover property (dc && $rose(dialing));
endmodule

/* File: tb_top.sv */
// self-checking bench for the signaling converter, 1 ms scaled to 50 cycles
// assumes the facility model in fsc_em_facility.sv
`timescale 1ns/1ps
module tb_top;
	localparam int MSC = 50;
	logic clk_sys, nrst, eCmd, loopClosed, invertSense, groundStart, ringGndReq;
	logic [1:0] appSel;
	logic eLeadGnd, ringUp, mLeadBattery, tipGround, suppressOn, idleTermOn, repeaterDisable;
	int unsigned lastBreak;
	int fails = 0;
	int total_checks = 0;

	fsc_signaling_converter #(.MS_CYCLES_P(MSC)) dut (.clk_sys(clk_sys), .nrst(nrst),
		.eLeadGnd(eLeadGnd), .loopClosed(loopClosed), .invertSense(invertSense),
		.groundStart(groundStart), .ringGndReq(ringGndReq), .appSel(appSel),
		.ringUpRelayDrive(ringUp), .mLeadBattery(mLeadBattery), .tipGround(tipGround),
		.suppressOn(suppressOn), .idleTermOn(idleTermOn), .repeaterDisable(repeaterDisable));

	fsc_em_facility far (.clk_sys(clk_sys), .nrst(nrst), .seizeReq(eCmd),
		.mLeadBattery(mLeadBattery), .eLeadGnd(eLeadGnd), .lastBreak(lastBreak));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input logic got, input logic exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic ms(input int n);
		cyc(n * MSC);
	endtask

	task automatic start(input logic [1:0] app, input logic gs, input logic inv, input logic eg);
		nrst = 1'b0;
		appSel = app;
		groundStart = gs;
		invertSense = inv;
		eCmd = eg;
		loopClosed = 1'b0;
		ringGndReq = 1'b0;
		cyc(20);
		nrst = 1'b1;
		ms(2);
	endtask

	task automatic finish_test();
		if (fails == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_ls_ring();
		for (int a = 0; a < 2; a++)
		begin
			start(2'(a), 1'b0, 1'b0, 1'b1);
			chk(ringUp, 1'b0, "ring while E grounded");
			eCmd = 1'b0;
			cyc(2);
			chk(ringUp, 1'b0, "ring before sync");
			cyc(2);
			chk(ringUp, 1'b1, "no ring on open E");
			chk(mLeadBattery, 1'b0, "M not ground while ringing");
			eCmd = 1'b1;
			cyc(4);
			chk(ringUp, 1'b0, "cadence not followed");
		end
	endtask

	task automatic t_invert();
		for (int a = 0; a < 3; a++)
		begin
			start(2'(a), 1'b0, 1'b1, 1'b0);
			chk(ringUp, 1'b0, "inverted ring on open E");
			eCmd = 1'b1;
			cyc(4);
			chk(ringUp, 1'b1, "inverted no ring");
			chk(mLeadBattery, 1'b0, "M moved by E lead");
		end
	endtask

	task automatic t_ls_hook();
		start(2'h0, 1'b0, 1'b0, 1'b1);
		loopClosed = 1'b1;
		ms(10);
		loopClosed = 1'b0;
		ms(20);
		chk(mLeadBattery, 1'b0, "short make taken");
		loopClosed = 1'b1;
		ms(13);
		chk(mLeadBattery, 1'b0, "make taken early");
		ms(5);
		chk(mLeadBattery, 1'b1, "off-hook not sent");
		loopClosed = 1'b0;
		ms(35);
		loopClosed = 1'b1;
		ms(80);
		chk(lastBreak >= 2400 && lastBreak <= 2600, 1'b1, "35 ms break not 50");
		loopClosed = 1'b0;
		ms(70);
		loopClosed = 1'b1;
		ms(80);
		chk(lastBreak >= 3400 && lastBreak <= 3600, 1'b1, "70 ms break altered");
		loopClosed = 1'b0;
		ms(10);
		loopClosed = 1'b1;
		ms(30);
		chk(mLeadBattery, 1'b1, "short break taken");
		chk(lastBreak >= 3400 && lastBreak <= 3600, 1'b1, "short break sent");
	endtask

	task automatic t_dc();
		for (int a = 1; a < 3; a++)
		begin
			start(2'(a), 1'b0, 1'b0, 1'b1);
			chk(suppressOn, 1'b1, "idle suppression off");
			chk(idleTermOn, 1'b1, "idle termination off");
			chk(repeaterDisable, 1'b1, "idle repeater enabled");
			loopClosed = 1'b1;
			ms(20);
			chk(mLeadBattery, 1'b0, "M not delayed");
			chk(idleTermOn, 1'b0, "termination kept");
			chk(repeaterDisable, 1'b0, "repeater kept off");
			ms(14);
			chk(mLeadBattery, 1'b1, "delayed M missing");
			loopClosed = 1'b0;
			ms(40);
			loopClosed = 1'b1;
			ms(30);
			chk(repeaterDisable, 1'b1, "dialing repeater on");
			chk(idleTermOn, 1'b0, "termination while dialing");
			chk(suppressOn, 1'b1, "dialing suppression off");
		end
	endtask

	task automatic t_gs();
		start(2'h0, 1'b1, 1'b1, 1'b0);
		chk(ringUp, 1'b0, "idle ring");
		chk(tipGround, 1'b0, "idle tip ground");
		chk(mLeadBattery, 1'b0, "idle M");
		ringGndReq = 1'b1;
		ms(2);
		chk(mLeadBattery, 1'b1, "request not sent");
		ringGndReq = 1'b0;
		eCmd = 1'b1;
		cyc(4);
		chk(tipGround, 1'b1, "tip ground missing");
		ms(2);
		eCmd = 1'b0;
		cyc(4);
		chk(ringUp, 1'b1, "alternation no ring");
		eCmd = 1'b1;
		cyc(4);
		chk(ringUp, 1'b0, "tone cadence");
		start(2'h1, 1'b1, 1'b0, 1'b0);
		eCmd = 1'b1;
		ms(2);
		eCmd = 1'b0;
		cyc(4);
		chk(ringUp, 1'b1, "dc ring missing");
		eCmd = 1'b1;
		ms(2);
		chk(ringUp, 1'b1, "dc ring not steady");
	endtask

	// ************************************************************
	// clock, sequence, watchdog
	// ************************************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial
	begin
		start(2'h0, 1'b0, 1'b0, 1'b1);
		t_ls_ring();
		t_invert();
		t_ls_hook();
		t_dc();
		t_gs();
		finish_test();
	end

	initial
	begin
		#1_500_000;
		fails++;
		finish_test();
	end
endmodule
